/* File: common/cfo_defs.svh */
/*
 Constants of the flag and operand logic: flag bit positions, operand widths, reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CFO_DEFS_SVH
`define CFO_DEFS_SVH

`define CFO_FLAG_V 4
`define CFO_FLAG_S 5
`define CFO_FLAG_Z 6
`define CFO_FLAG_C 7
`define CFO_FLAGS_RST 8'h00
`define CFO_FLAGS_ADDR 8'hd5
`define CFO_WR_BASE_HI 4'hc
`define CFO_MEM_AW 13
`define CFO_OP_COUNT 41

`endif

/* File: common/cfo_pkg.sv */
/*
 Types of the flag and operand logic: operation codes and addressing modes.
 Assumes the defs header for numeric constants.
*/
`default_nettype none
package cfo_pkg;

	// Operation selected by the decoder outside this block
	typedef enum logic [4:0] {
		CFO_NOP = 5'h00,
		CFO_ADD = 5'h01,
		CFO_ADC = 5'h02,
		CFO_SUB = 5'h03,
		CFO_SBC = 5'h04,
		CFO_CP = 5'h05,
		CFO_INC = 5'h06,
		CFO_DEC = 5'h07,
		CFO_AND = 5'h08,
		CFO_OR = 5'h09,
		CFO_XOR = 5'h0a,
		CFO_COM = 5'h0b,
		CFO_TM = 5'h0c,
		CFO_TCM = 5'h0d,
		CFO_RL = 5'h0e,
		CFO_RLC = 5'h0f,
		CFO_RR = 5'h10,
		CFO_RRC = 5'h11,
		CFO_SRA = 5'h12,
		CFO_LOAD = 5'h13,
		CFO_CARRY_SET = 5'h14,
		CFO_CARRY_CLR = 5'h15,
		CFO_CARRY_INV = 5'h16,
		CFO_ISR_RET = 5'h17
	} cfo_op_t;

	// Operand addressing modes
	typedef enum logic [2:0] {
		CFO_AM_REG = 3'h0,
		CFO_AM_IND = 3'h1,
		CFO_AM_IDX = 3'h2,
		CFO_AM_DIR = 3'h3,
		CFO_AM_REL = 3'h4,
		CFO_AM_IMM = 3'h5
	} cfo_amode_t;

endpackage
`default_nettype wire

/* File: rtl/cfo_addr_gen.sv */
/*
 Operand address generator: register, indirect, indexed, direct, relative, immediate.
 Assumes register read data for indirect and indexed modes is supplied combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfo_defs.svh"

module cfo_addr_gen
	import cfo_pkg::*;
(
	// Mode and fields
	input wire cfo_amode_t amode,
	input wire logic short_sel,
	input wire logic [3:0] wreg,
	input wire logic [7:0] field,
	input wire logic [12:0] long_field,
	input wire logic pair_sel,
	// Register data and program counter
	input wire logic [7:0] reg_data,
	input wire logic [7:0] pair_hi,
	input wire logic [7:0] pair_lo,
	input wire logic [12:0] pc_next,
	// Results
	output logic [7:0] reg_addr,
	output logic [12:0] mem_addr,
	output logic mem_valid,
	output logic [7:0] imm_data,
	output logic imm_valid
);

	wire logic [7:0] base_reg;
	wire logic [12:0] pair_addr;
	wire logic [12:0] rel_addr;
	wire logic [12:0] idx_addr;

	// 4-bit working register maps into the working block of the 8-bit space
	assign base_reg = short_sel ? {`CFO_WR_BASE_HI, wreg} : field;
	assign pair_addr = {pair_hi[4:0], pair_lo};
	assign rel_addr = pc_next + {{5{field[7]}}, field};
	assign idx_addr = pair_addr + long_field;

	// Mode decode
	assign reg_addr = (amode == CFO_AM_IND) ? reg_data :
		(amode == CFO_AM_IDX && !pair_sel) ? 8'(field + reg_data) : base_reg;
	assign mem_addr = (amode == CFO_AM_DIR) ? long_field :
		(amode == CFO_AM_REL) ? rel_addr :
		(amode == CFO_AM_IDX) ? idx_addr : pair_addr;
	assign mem_valid = (amode == CFO_AM_DIR) || (amode == CFO_AM_REL) ||
		(amode == CFO_AM_IDX && pair_sel) || (amode == CFO_AM_IND && pair_sel);
	assign imm_data = field;
	assign imm_valid = (amode == CFO_AM_IMM);

endmodule
`default_nettype wire

/* File: rtl/cfo_flags_alu.sv */
/*
 Flag and operand datapath of the 8-bit core: ALU, flags register, global interrupt enable.
 Assumes an instruction decoder issuing one-cycle op_valid strobes with operands.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfo_defs.svh"

module cfo_flags_alu
	import cfo_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Operation request
	input wire logic op_valid,
	input wire cfo_op_t op,
	input wire logic [7:0] dst_val,
	input wire logic [7:0] src_val,
	// Operand addressing
	input wire cfo_amode_t amode,
	input wire logic short_sel,
	input wire logic [3:0] wreg,
	input wire logic [7:0] field,
	input wire logic [12:0] long_field,
	input wire logic pair_sel,
	input wire logic [7:0] reg_data,
	input wire logic [7:0] pair_hi,
	input wire logic [7:0] pair_lo,
	input wire logic [12:0] pc_next,
	// Direct flags write and stacked flags
	input wire logic flags_wr,
	input wire logic [7:0] flags_wdata,
	input wire logic [7:0] stacked_flags,
	// Interrupt enable control
	input wire logic irq_enable_op,
	input wire logic irq_disable_op,
	// Results
	output logic [7:0] result_r,
	output logic result_we_r,
	output logic [7:0] flags_r,
	output logic [3:0] cond_flags_r,
	output logic global_irq_enable_bit_r,
	output logic [7:0] reg_addr_r,
	output logic [12:0] mem_addr_r,
	output logic mem_valid_r,
	output logic [7:0] imm_r,
	output logic imm_valid_r
);

	wire logic [7:0] ag_reg;
	wire logic [12:0] ag_mem;
	wire logic ag_mem_v;
	wire logic [7:0] ag_imm;
	wire logic ag_imm_v;

	cfo_addr_gen u_addr (
		.amode(amode),
		.short_sel(short_sel),
		.wreg(wreg),
		.field(field),
		.long_field(long_field),
		.pair_sel(pair_sel),
		.reg_data(reg_data),
		.pair_hi(pair_hi),
		.pair_lo(pair_lo),
		.pc_next(pc_next),
		.reg_addr(ag_reg),
		.mem_addr(ag_mem),
		.mem_valid(ag_mem_v),
		.imm_data(ag_imm),
		.imm_valid(ag_imm_v)
	);

	// ----------------------------------------
	// Operation decode
	// ----------------------------------------
	// Control ops of the instruction set that touch only flags or enable
	wire logic op_isr_ret = op_valid && (op == CFO_ISR_RET);
	wire logic op_c_set = op_valid && (op == CFO_CARRY_SET);
	wire logic op_c_clr = op_valid && (op == CFO_CARRY_CLR);
	wire logic op_c_inv = op_valid && (op == CFO_CARRY_INV);
	wire logic op_carry = op_c_set || op_c_clr || op_c_inv;
	// Ops that produce no destination value
	wire logic op_no_dst = (op == CFO_NOP) || (op == CFO_CP) || (op == CFO_TM) ||
		(op == CFO_TCM) || (op == CFO_CARRY_SET) || (op == CFO_CARRY_CLR) ||
		(op == CFO_CARRY_INV) || (op == CFO_ISR_RET);
	// Carry value chosen by the dedicated carry ops
	wire logic carry_op_val = op_c_set ? 1'b1 : op_c_clr ? 1'b0 : ~flags_r[`CFO_FLAG_C];

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [8:0] s;
		logic v;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		v = (a[7] == b[7]) && (s[7] != a[7]);
		add8 = {v, s};
	endfunction

	wire logic cy = flags_r[`CFO_FLAG_C];
	wire logic is_sub = (op == CFO_SUB) || (op == CFO_SBC) || (op == CFO_CP) ||
		(op == CFO_DEC);
	wire logic [7:0] b_in = (op == CFO_INC || op == CFO_DEC) ? 8'h01 : src_val;
	wire logic sub_cin = (op == CFO_SBC) ? ~cy : 1'b1;
	wire logic add_cin = (op == CFO_ADC) ? cy : 1'b0;
	wire logic [9:0] sum = add8(dst_val, is_sub ? ~b_in : b_in, is_sub ? sub_cin : add_cin);
	wire logic arith_c = is_sub ? ~sum[8] : sum[8]; // Borrow is inverted carry

	// ----------------------------------------
	// Result select
	// ----------------------------------------
	// Instruction groups that move the flags
	wire logic is_arith = (op == CFO_ADD) || (op == CFO_ADC) || is_sub || (op == CFO_INC);
	wire logic is_logic = (op == CFO_AND) || (op == CFO_OR) || (op == CFO_XOR) ||
		(op == CFO_COM) || (op == CFO_TM) || (op == CFO_TCM);
	wire logic is_shift = (op == CFO_RL) || (op == CFO_RLC) || (op == CFO_RR) ||
		(op == CFO_RRC) || (op == CFO_SRA);
	wire logic [7:0] res =
		is_arith ? sum[7:0] :
		(op == CFO_AND || op == CFO_TM) ? (dst_val & src_val) :
		(op == CFO_TCM) ? (~dst_val & src_val) :
		(op == CFO_OR) ? (dst_val | src_val) :
		(op == CFO_XOR) ? (dst_val ^ src_val) :
		(op == CFO_COM) ? ~dst_val :
		(op == CFO_RL) ? {dst_val[6:0], dst_val[7]} :
		(op == CFO_RLC) ? {dst_val[6:0], cy} :
		(op == CFO_RR) ? {dst_val[0], dst_val[7:1]} :
		(op == CFO_RRC) ? {cy, dst_val[7:1]} :
		(op == CFO_SRA) ? {dst_val[7], dst_val[7:1]} : src_val;
	wire logic shift_c = (op == CFO_RL || op == CFO_RLC) ? dst_val[7] : dst_val[0];
	wire logic writes = op_valid && !op_no_dst;

	// ----------------------------------------
	// Flag update
	// ----------------------------------------
	wire logic upd = op_valid && (is_arith || is_logic || is_shift);
	wire logic new_c = is_arith ? arith_c : is_shift ? shift_c : cy;
	wire logic new_z = (res == 8'h00);
	wire logic new_s = res[7];
	// Shifts flag overflow when the sign bit changes
	wire logic new_v = is_arith ? sum[9] : is_logic ? 1'b0 :
		(res[7] ^ dst_val[7]);
	// Low nibble untouched by flag-affecting ops
	wire logic [7:0] upd_flags = {new_c, new_z, new_s, new_v, flags_r[3:0]};
	// A software write loses to an op that moves the flags in the same cycle
	wire logic [7:0] flags_nxt =
		op_isr_ret ? stacked_flags :
		upd ? upd_flags :
		op_carry ? {carry_op_val, flags_r[6:0]} :
		flags_wr ? flags_wdata : flags_r; // Register-space write
	// Enable wins over disable when both strobe
	wire logic gie_nxt = op_isr_ret ? 1'b1 :
		irq_enable_op ? 1'b1 : irq_disable_op ? 1'b0 : global_irq_enable_bit_r;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			flags_r <= `CFO_FLAGS_RST;
			cond_flags_r <= 4'h0;
			global_irq_enable_bit_r <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			cond_flags_r <= flags_nxt[7:4];
			global_irq_enable_bit_r <= gie_nxt;
		end
	end

	// Result stands for one cycle beside its write strobe
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			result_r <= 8'h00;
			result_we_r <= 1'b0;
		end else begin
			result_r <= res;
			result_we_r <= writes;
		end
	end

	// ----------------------------------------
	// Operand address outputs
	// ----------------------------------------
	// Registered every cycle so the addresses line up with the op they serve
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			reg_addr_r <= 8'h00;
			mem_addr_r <= 13'h0000;
			mem_valid_r <= 1'b0;
			imm_r <= 8'h00;
			imm_valid_r <= 1'b0;
		end else begin
			reg_addr_r <= ag_reg;
			mem_addr_r <= ag_mem;
			mem_valid_r <= ag_mem_v;
			imm_r <= ag_imm;
			imm_valid_r <= ag_imm_v;
		end
	end

endmodule
`default_nettype wire

/* File: testbench/cfo_flags_alu_properties.sv */
/* Flag output checker of cfo_flags_alu.
 Assumes binding to the ports of that module. */
`timescale 1ns/1ps
`default_nettype none
module cfo_chk
	import cfo_pkg::*;
(
	// Clock and request
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic op_valid,
	input wire cfo_op_t op,
	input wire logic [7:0] dst_val,
	input wire logic flags_wr,
	input wire logic [7:0] stacked_flags,
	// Results
	input wire logic [7:0] result_r,
	input wire logic [7:0] flags_r,
	input wire logic [3:0] cond_flags_r,
	input wire logic global_irq_enable_bit_r
);
	// --
	// Properties
	// --
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_alu;
		op_valid && op inside {[CFO_ADD:CFO_SBC], CFO_INC, CFO_DEC, [CFO_AND:CFO_COM],
			[CFO_RL:CFO_SRA]};
	endsequence
	a_cond_mirror: assert property (cond_flags_r == flags_r[7:4])
		else $error("cond flags differ");
	a_load_keeps: assert property (
		op_valid && op == CFO_LOAD && !flags_wr |=> $stable(flags_r))
		else $error("load changed flags");
	a_logic_v_clear: assert property (
		op_valid && op inside {[CFO_AND:CFO_COM]} |=> !flags_r[4])
		else $error("overflow left by logic op");
	a_sign_msb: assert property (s_alu |=> flags_r[5] == result_r[7])
		else $error("sign differs from msb");
	a_zero_result: assert property (s_alu |=> flags_r[6] == (result_r == 8'h00))
		else $error("zero flag wrong");
	a_low_nibble: assert property (
		op_valid && op != CFO_ISR_RET && !flags_wr |=> flags_r[3:0] == $past(flags_r[3:0]))
		else $error("low flag bits changed");
	a_carry_ops: assert property (
		op_valid && op inside {[CFO_CARRY_SET:CFO_CARRY_INV]} && !flags_wr |=>
		flags_r[6:0] == $past(flags_r[6:0]) && flags_r[7] == ($past(op) == CFO_CARRY_SET
		|| ($past(op) == CFO_CARRY_INV && !$past(flags_r[7]))))
		else $error("carry op wrong");
	a_rot_carry: assert property (
		op_valid && op inside {[CFO_RL:CFO_SRA]} |=> flags_r[7] == ($past(op) inside
		{CFO_RL, CFO_RLC} ? $past(dst_val[7]) : $past(dst_val[0])))
		else $error("shift carry wrong");
	a_isr_return: assert property (
		op_valid && op == CFO_ISR_RET |=> global_irq_enable_bit_r && flags_r == $past(stacked_flags))
		else $error("isr return state wrong");
endmodule
bind cfo_flags_alu cfo_chk i_chk (.clk_sys, .resetn, .op_valid, .op, .dst_val, .flags_wr,
	.stacked_flags, .result_r, .flags_r, .cond_flags_r, .global_irq_enable_bit_r);
`default_nettype wire

/* File: testbench/cfo_flags_alu_tb.sv */
/* Bench of cfo_flags_alu: table of ops, carry ops, isr return, addressing.
 Assumes the bound checker and one 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module cfo_flags_alu_tb
	import cfo_pkg::*;
;
	logic clk_sys = 1'b0, resetn = 1'b0, op_valid = 1'b0, short_sel = 1'b1, flags_wr = 1'b0;
	cfo_op_t op = CFO_NOP;
	cfo_amode_t amode = CFO_AM_REG;
	logic [7:0] dst_val = 8'h00, src_val = 8'h00, flags_wdata = 8'h00, stacked_flags = 8'h5a;
	logic [7:0] field = 8'h5c, pair_hi = 8'hff, pair_lo = 8'h34, result_r, flags_r, reg_addr_r, imm_r;
	logic [3:0] wreg = 4'h3, cond_flags_r;
	logic [12:0] long_field = 13'h1abc, pc_next = 13'h0100, mem_addr_r;
	logic result_we_r, global_irq_enable_bit_r, mem_valid_r, imm_valid_r;
	logic pair_sel = 1'b1;
	logic [7:0] reg_data = 8'h21;
	// Rows: op, dst, src, result, flags, flag mask
	logic [47:0] tbl[18] = '{48'h017f01803_0ff, 48'h01ff0100c0ff, 48'h0210203100ff,
		48'h030001ffa0ff, 48'h0380017f10ff, 48'h0400000040ff, 48'h067f00803_0ff,
		48'h070000ffa0ff, 48'h080ff0004070, 48'h098001812070, 48'h0affff004070,
		48'h0b7f00802070, 48'h0e81000380e0, 48'h10010080a0e0, 48'h1201000_0c0e0,
		48'h128000c020e0, 48'h0f800000c0e0, 48'h1100008020e0};
	cfo_op_t c_ops[4] = '{CFO_CARRY_SET, CFO_CARRY_INV, CFO_CARRY_INV, CFO_CARRY_CLR};
	int err_total = 0, compares = 0;

	cfo_flags_alu i_dut (.clk_sys, .resetn, .op_valid, .op, .dst_val, .src_val, .amode, .short_sel,
		.wreg, .field, .long_field, .pair_sel, .reg_data, .pair_hi, .pair_lo,
		.pc_next, .flags_wr, .flags_wdata, .stacked_flags, .irq_enable_op(1'b0),
		.irq_disable_op(1'b0), .result_r, .result_we_r, .flags_r, .cond_flags_r,
		.global_irq_enable_bit_r, .reg_addr_r, .mem_addr_r, .mem_valid_r, .imm_r, .imm_valid_r);

	always #5 clk_sys = ~clk_sys;

	// --
	// Tasks
	// --
	task automatic ck(input logic [12:0] got, input logic [12:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic run(input cfo_op_t o, input logic [7:0] d, input logic [7:0] s);
		@(posedge clk_sys);
		op_valid <= 1'b1;
		op <= o;
		dst_val <= d;
		src_val <= s;
		@(posedge clk_sys);
		op_valid <= 1'b0;
		#1;
	endtask

	task automatic am(input cfo_amode_t m, input logic s);
		@(posedge clk_sys);
		amode <= m;
		short_sel <= s;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic end_sim;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		foreach (tbl[i]) begin
			run(cfo_op_t'(tbl[i][44:40]), tbl[i][39:32], tbl[i][31:24]);
			ck(result_r, tbl[i][23:16]);
			ck(flags_r & tbl[i][7:0], tbl[i][15:8]);
		end
		run(CFO_LOAD, 8'h55, 8'h66);
		ck(flags_r, 8'h30);
		ck(result_r, 8'h66);
		ck(result_we_r, 1'b1);
		$display("ops done");
		@(posedge clk_sys);
		flags_wr <= 1'b1;
		flags_wdata <= 8'h0a;
		@(posedge clk_sys);
		flags_wr <= 1'b0;
		#1;
		ck(flags_r, 8'h0a);
		foreach (c_ops[i]) begin
			run(c_ops[i], 8'h00, 8'h00);
			ck(flags_r, {~i[0], 7'h0a});
			ck(cond_flags_r, {~i[0], 3'h0});
		end
		run(CFO_ADD, 8'h01, 8'h01);
		ck(flags_r, 8'h0a);
		$display("carry done");
		run(CFO_ISR_RET, 8'h00, 8'h00);
		ck(flags_r, 8'h5a);
		ck(global_irq_enable_bit_r, 1'b1);
		ck(result_we_r, 1'b0);
		$display("isr done");
		am(CFO_AM_REG, 1'b1);
		ck(reg_addr_r, 8'hc3);
		am(CFO_AM_REG, 1'b0);
		ck(reg_addr_r, 8'h5c);
		am(CFO_AM_DIR, 1'b0);
		ck(mem_addr_r, 13'h1abc);
		ck(mem_valid_r, 1'b1);
		am(CFO_AM_IND, 1'b0);
		ck(mem_addr_r, 13'h1f34);
		ck(reg_addr_r, 8'h21);
		am(CFO_AM_IMM, 1'b0);
		ck(imm_r, 8'h5c);
		ck(imm_valid_r, 1'b1);
		am(CFO_AM_IDX, 1'b0);
		ck(mem_addr_r, 13'h19f0);
		am(CFO_AM_REL, 1'b0);
		ck(mem_addr_r, 13'h015c);
		ck(mem_valid_r, 1'b1);
		pair_sel <= 1'b0;
		am(CFO_AM_IDX, 1'b0);
		ck(reg_addr_r, 8'h7d);
		ck(mem_valid_r, 1'b0);
		$display("addr done");
		end_sim();
	end
endmodule
`default_nettype wire
